//--- pkg/spicsr_pkg.sv
package spicsr_pkg;

  // ****************************************************************
  // Register map: printed offsets are word indices
  // ****************************************************************
  localparam int          ADDR_W    = 12;
  localparam logic [9:0]  IDX_CTRL  = 10'h010;
  localparam logic [9:0]  IDX_STAT  = 10'h011;
  localparam logic [9:0]  IDX_DATA  = 10'h012;
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [11:0] ADDR_DATA = {IDX_DATA, 2'b00};

  // ****************************************************************
  // serial_control fields
  // ****************************************************************
  localparam int B_RXIE = 7;
  localparam int B_MSTR = 5;
  localparam int B_CPOL = 4;
  localparam int B_CPHA = 3;
  localparam int B_ODRN = 2;
  localparam int B_MEN  = 1;
  localparam int B_TXIE = 0;
  localparam logic [7:0] CTRL_RST = 8'h28;

  // ****************************************************************
  // serial_status_control fields
  // ****************************************************************
  localparam int B_RXF  = 7;
  localparam int B_ERIE = 6;
  localparam int B_OVR  = 5;
  localparam int B_MODE_FAULT_FLAG = 4;
  localparam int B_TXE  = 3;
  localparam int B_FDE  = 2;
  localparam int B_RHI  = 1;
  localparam int B_RLO  = 0;
  localparam logic [7:0] STAT_RST = 8'h08;

  // ****************************************************************
  // Master baud divisors, full SCK periods in bus cycles, and their half periods
  // ****************************************************************
  localparam int DIV_0 = 2;
  localparam int DIV_1 = 8;
  localparam int DIV_2 = 32;
  localparam int DIV_3 = 128;
  localparam logic [6:0] HALF_0 = 7'(DIV_0 / 2);
  localparam logic [6:0] HALF_1 = 7'(DIV_1 / 2);
  localparam logic [6:0] HALF_2 = 7'(DIV_2 / 2);
  localparam logic [6:0] HALF_3 = 7'(DIV_3 / 2);
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    SPICSR_IDLE = 2'b01,
    SPICSR_RUN  = 2'b10
  } spicsr_state_e;

endpackage

//--- design/spicsr_sync.sv
module spicsr_sync import spicsr_pkg::*; #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } spicsr_sync_s;

  spicsr_sync_s s;
  spicsr_sync_s next_s;

  always_comb begin
    next_s.meta = din;
    next_s.sync = s.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.sync;

endmodule

//--- design/spicsr_shift.sv
module spicsr_shift import spicsr_pkg::*; (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  input  wire logic       master,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       tick,
  input  wire logic       sck_s,
  input  wire logic       sdi_s,
  input  wire logic       ss_n_s,
  input  wire logic       tx_full,
  input  wire logic [7:0] tx_byte,
  output logic            take,
  output logic            done,
  output logic      [7:0] rx_byte,
  output logic            sck_o,
  output logic            sdo,
  output logic            busy
);

  typedef struct packed {
    spicsr_state_e st;
    logic [7:0]    sr;
    logic          rxb;
    logic [2:0]    cnt;
    logic          act;
    logic          sck_d;
    logic          sdo;
    logic          take;
    logic          done;
    logic [7:0]    rx;
  } spicsr_shift_s;

  spicsr_shift_s s;
  spicsr_shift_s next_s;

  always_comb begin
    logic lead;
    logic trail;
    logic live;
    logic [7:0] nsr;
    lead   = 1'b0;
    trail  = 1'b0;
    live   = 1'b0;
    nsr    = '0;
    next_s = s;
    next_s.take  = 1'b0;
    next_s.done  = 1'b0;
    next_s.sck_d = sck_s;
    if (master) begin
      if (s.st == SPICSR_RUN && tick) begin
        lead       = !s.act;
        trail      = s.act;
        next_s.act = !s.act;
      end
    end else if (!ss_n_s && sck_s != s.sck_d) begin
      // Deselected slave ignores every clock edge
      lead  = (sck_s != cpol);
      trail = !lead;
    end
    case (s.st)
      SPICSR_IDLE: begin
        if (tx_full && !lead) begin
          next_s.sr   = tx_byte;
          next_s.sdo  = tx_byte[7];
          next_s.take = 1'b1;
          next_s.cnt  = '0;
          next_s.act  = 1'b0;
          if (master) begin
            next_s.st = SPICSR_RUN;
          end
        end
        live = !master && lead;
        if (live) begin
          next_s.st = SPICSR_RUN;
        end
      end
      SPICSR_RUN: begin
        live = 1'b1;
      end
      default: begin
        next_s.st = SPICSR_IDLE;
      end
    endcase
    if (live && lead) begin
      if (cpha) begin
        next_s.sdo = s.sr[7];
      end else begin
        next_s.rxb = sdi_s;
      end
    end
    // Master input passes the synchroniser: receive needs divisor 8 or more
    if (live && trail) begin
      nsr        = {s.sr[6:0], (cpha ? sdi_s : s.rxb)};
      next_s.sr  = nsr;
      next_s.cnt = s.cnt + 3'h1;
      if (!cpha) begin
        next_s.sdo = s.sr[6];
      end
      if (s.cnt == LAST_BIT) begin
        next_s.done = 1'b1;
        next_s.rx   = nsr;
        next_s.st   = SPICSR_IDLE;
      end
    end
    if (!master && ss_n_s && s.st == SPICSR_RUN) begin
      next_s.st  = SPICSR_IDLE;
      next_s.cnt = '0;
    end
    // Disabled module: abort, clear shifter and counter
    if (!en) begin
      next_s.st  = SPICSR_IDLE;
      next_s.sr  = '0;
      next_s.cnt = '0;
      next_s.act = 1'b0;
      next_s.sdo = 1'b0;
      next_s.take = 1'b0;
      next_s.done = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s    <= '0;
      s.st <= SPICSR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign take    = s.take;
  assign done    = s.done;
  assign rx_byte = s.rx;
  assign sck_o   = s.act ^ cpol;
  assign sdo     = s.sdo;
  assign busy    = (s.st == SPICSR_RUN);

endmodule

//--- design/spicsr_top.sv
module spicsr_top import spicsr_pkg::*; (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sck_in,
  output logic                   sck_out,
  output logic                   sck_oe_n,
  input  wire logic              mosi_in,
  output logic                   mosi_out,
  output logic                   mosi_oe_n,
  input  wire logic              miso_in,
  output logic                   miso_out,
  output logic                   miso_oe_n,
  input  wire logic              ss_n_in,
  output logic                   ss_owned,
  output logic                   pullup_en,
  output logic                   rx_irq_req,
  output logic                   tx_irq_req,
  output logic                   err_irq_req
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic       rx_arm;
    logic       ovr_arm;
    logic       mode_fault_flag_arm;
    logic       ss_d;
    logic [6:0] div_cnt;
    logic       tick;
    logic       pready;
    logic       pslverr;
    logic [7:0] prdata;
    logic       sck_out;
    logic       sck_oe_n;
    logic       mosi_out;
    logic       mosi_oe_n;
    logic       miso_out;
    logic       miso_oe_n;
    logic       ss_owned;
    logic       pullup_en;
    logic       rx_irq;
    logic       tx_irq;
    logic       err_irq;
  } spicsr_top_s;

  spicsr_top_s s;
  spicsr_top_s next_s;
  logic [7:0]  tx_buf;
  logic [7:0]  rx_buf;
  logic        tx_wr;
  logic        rx_ld;

  logic [3:0]  pins_s;
  logic        sck_s;
  logic        mosi_s;
  logic        miso_s;
  logic        ss_n_s;
  logic        sh_take;
  logic        sh_done;
  logic [7:0]  sh_rx;
  logic        sh_sck;
  logic        sh_sdo;
  logic        sh_busy;

  // ****************************************************************
  // Pin synchronisers and shift engine
  // ****************************************************************
  spicsr_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({sck_in, mosi_in, miso_in, ss_n_in}),
    .dout    (pins_s)
  );
  assign {sck_s, mosi_s, miso_s, ss_n_s} = pins_s;

  spicsr_shift u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (s.ctrl[B_MEN]),
    .master  (s.ctrl[B_MSTR]),
    .cpol    (s.ctrl[B_CPOL]),
    .cpha    (s.ctrl[B_CPHA]),
    .tick    (s.tick),
    .sck_s   (sck_s),
    .sdi_s   (s.ctrl[B_MSTR] ? miso_s : mosi_s),
    .ss_n_s  (ss_n_s),
    .tx_full (!s.stat[B_TXE]),
    .tx_byte (tx_buf),
    .take    (sh_take),
    .done    (sh_done),
    .rx_byte (sh_rx),
    .sck_o   (sh_sck),
    .sdo     (sh_sdo),
    .busy    (sh_busy)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic setup;
    logic fin;
    logic wr_ctrl;
    logic wr_data;
    logic rd_stat;
    logic rd_data;
    logic rx_clr;
    logic en;
    logic mst;
    logic od;
    logic [6:0] half;
    setup   = psel && !penable;
    fin     = psel && penable && s.pready;
    wr_ctrl = fin && pwrite && paddr == ADDR_CTRL;
    wr_data = fin && pwrite && paddr == ADDR_DATA;
    rd_stat = fin && !pwrite && paddr == ADDR_STAT;
    rd_data = fin && !pwrite && paddr == ADDR_DATA;
    rx_clr  = rd_data && s.rx_arm;
    en      = s.ctrl[B_MEN];
    mst     = s.ctrl[B_MSTR];
    od      = s.ctrl[B_ODRN];
    half    = HALF_0;
    next_s  = s;
    tx_wr   = wr_data;
    rx_ld   = 1'b0;

    // Zero wait states: answer in the first access cycle
    next_s.pready  = setup;
    next_s.pslverr = 1'b0;
    if (setup && !pwrite) begin
      case (paddr)
        ADDR_CTRL: next_s.prdata = s.ctrl;
        ADDR_STAT: next_s.prdata = s.stat;
        ADDR_DATA: next_s.prdata = rx_buf;
        default: begin
          next_s.prdata  = '0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end else if (setup) begin
      next_s.pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_DATA);
    end

    if (wr_ctrl) begin
      next_s.ctrl = pwdata[7:0];
      next_s.ctrl[6] = 1'b0;
    end
    if (fin && pwrite && paddr == ADDR_STAT) begin
      next_s.stat[B_ERIE] = pwdata[B_ERIE];
      next_s.stat[B_FDE]  = pwdata[B_FDE];
      next_s.stat[B_RHI]  = pwdata[B_RHI];
      next_s.stat[B_RLO]  = pwdata[B_RLO];
    end

    // Two-step clears: arm on a status read that saw the flag
    if (rd_stat) begin
      next_s.rx_arm   = s.rx_arm | s.prdata[B_RXF];
      next_s.ovr_arm  = s.ovr_arm | s.prdata[B_OVR];
      next_s.mode_fault_flag_arm = s.mode_fault_flag_arm | s.prdata[B_MODE_FAULT_FLAG];
    end
    if (rd_data) begin
      next_s.rx_arm  = 1'b0;
      next_s.ovr_arm = 1'b0;
      if (s.rx_arm) begin
        next_s.stat[B_RXF] = 1'b0;
      end
      if (s.ovr_arm) begin
        next_s.stat[B_OVR] = 1'b0;
      end
    end
    if (wr_ctrl && s.mode_fault_flag_arm) begin
      next_s.stat[B_MODE_FAULT_FLAG] = 1'b0;
      next_s.mode_fault_flag_arm     = 1'b0;
    end

    // Received byte; a same-cycle clear counts as a read
    if (sh_done) begin
      if (s.stat[B_RXF] && !rx_clr) begin
        next_s.stat[B_OVR] = 1'b1;
      end else begin
        next_s.stat[B_RXF] = 1'b1;
        rx_ld = 1'b1;
      end
    end

    if (wr_data) begin
      next_s.stat[B_TXE] = 1'b0;
    end
    if (sh_take || !en) begin
      next_s.stat[B_TXE] = 1'b1;
    end

    // Mode fault detection, set wins over the clear above
    next_s.ss_d = ss_n_s;
    if (en && s.stat[B_FDE]) begin
      if (mst && !ss_n_s) begin
        next_s.stat[B_MODE_FAULT_FLAG] = 1'b1;
        next_s.ctrl[B_MEN]  = 1'b0;
      end
      if (!mst && ss_n_s && !s.ss_d && sh_busy) begin
        next_s.stat[B_MODE_FAULT_FLAG] = 1'b1;
      end
    end

    // Baud divider, only for an enabled master
    case ({s.stat[B_RHI], s.stat[B_RLO]})
      2'b00:   half = HALF_0;
      2'b01:   half = HALF_1;
      2'b10:   half = HALF_2;
      2'b11:   half = HALF_3;
      default: half = HALF_0;
    endcase
    next_s.tick = 1'b0;
    if (en && mst && sh_busy) begin
      if (s.div_cnt >= half - 7'h1) begin
        next_s.div_cnt = '0;
        next_s.tick    = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 7'h1;
      end
    end else begin
      next_s.div_cnt = '0;
    end

    // Pins: open-drain only ever pulls low
    next_s.sck_out   = sh_busy ? sh_sck : s.ctrl[B_CPOL];
    next_s.mosi_out  = sh_sdo;
    next_s.miso_out  = sh_sdo;
    next_s.sck_oe_n  = !(en && mst && (!od || !next_s.sck_out));
    next_s.mosi_oe_n = !(en && mst && (!od || !sh_sdo));
    next_s.miso_oe_n = !(en && !mst && !ss_n_s && (!od || !sh_sdo));
    next_s.pullup_en = !od;
    next_s.ss_owned  = en && (!mst || s.stat[B_FDE]);

    next_s.rx_irq  = s.stat[B_RXF] && s.ctrl[B_RXIE];
    next_s.tx_irq  = s.stat[B_TXE] && s.ctrl[B_TXIE];
    next_s.err_irq = s.stat[B_ERIE] && (s.stat[B_MODE_FAULT_FLAG] || s.stat[B_OVR]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.ctrl      <= CTRL_RST;
      s.stat      <= STAT_RST;
      s.ss_d      <= 1'b1;
      s.sck_oe_n  <= 1'b1;
      s.mosi_oe_n <= 1'b1;
      s.miso_oe_n <= 1'b1;
      s.pullup_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Data buffers keep their content across reset
  always_ff @(posedge pclk) begin
    if (tx_wr) begin
      tx_buf <= pwdata[7:0];
    end
    if (rx_ld) begin
      rx_buf <= sh_rx;
    end
  end

  assign prdata      = {24'h000000, s.prdata};
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign sck_out     = s.sck_out;
  assign sck_oe_n    = s.sck_oe_n;
  assign mosi_out    = s.mosi_out;
  assign mosi_oe_n   = s.mosi_oe_n;
  assign miso_out    = s.miso_out;
  assign miso_oe_n   = s.miso_oe_n;
  assign ss_owned    = s.ss_owned;
  assign pullup_en   = s.pullup_en;
  assign rx_irq_req  = s.rx_irq;
  assign tx_irq_req  = s.tx_irq;
  assign err_irq_req = s.err_irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  rx_irq_a: assert property (s.stat[B_RXF] && s.ctrl[B_RXIE] |=> rx_irq_req)
    else $error("rx interrupt not raised");
  err_irq_a: assert property (!s.stat[B_ERIE] |=> !err_irq_req)
    else $error("error interrupt while disabled");
  rx_set_a: assert property (sh_done && !s.stat[B_RXF] |=> s.stat[B_RXF] && rx_buf == $past(sh_rx))
    else $error("rx byte not stored");
  ovr_keep_a: assert property (sh_done && s.stat[B_RXF] && !(psel && penable && pready
                               && !pwrite && paddr == ADDR_DATA)
                               |=> s.stat[B_OVR] && $stable(rx_buf))
    else $error("overrun not flagged");
  rx_clr_a: assert property (psel && penable && pready && !pwrite && paddr == ADDR_DATA
                             && s.rx_arm && !sh_done |=> !s.stat[B_RXF])
    else $error("rx flag not cleared");
  mode_fault_flag_mst_a: assert property (s.ctrl[B_MEN] && s.ctrl[B_MSTR] && s.stat[B_FDE] && !ss_n_s
                               |=> s.stat[B_MODE_FAULT_FLAG] && !s.ctrl[B_MEN])
    else $error("master mode fault missed");
  tx_clr_a: assert property (psel && penable && pready && pwrite && paddr == ADDR_DATA
                             && s.ctrl[B_MEN] && !sh_take |=> !s.stat[B_TXE])
    else $error("tx empty not cleared");
  disable_a: assert property (!s.ctrl[B_MEN] |=> s.stat[B_TXE] && !sh_busy)
    else $error("disabled block still busy");
  mode_fault_flag_keep_a: assert property (s.stat[B_MODE_FAULT_FLAG] && !(psel && penable && pwrite
                                && paddr == ADDR_CTRL) |=> s.stat[B_MODE_FAULT_FLAG])
    else $error("mode fault lost");

endmodule

//--- tb/spicsr_peer.sv
module spicsr_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       cpol,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr = 8'h00;
  int         cnt = 0;
  // ****************************************************************
  // Phase-1 slave: limitation, phase-0 framing is not modelled
  // ****************************************************************
  initial miso = 1'b0;
  initial rx = 8'h00;
  always @(sck) begin
    if (!sel_n) begin
      if (sck != cpol) begin
        if (cnt == 0) sr = tx;
        miso = sr[7];
      end else begin
        sr = {sr[6:0], mosi};
        cnt = cnt + 1;
        if (cnt == 8) begin
          rx = sr;
          cnt = 0;
        end
      end
    end
  end
  // Released line shows the inverse so a stale bit is never read
  always @(posedge sel_n) begin
    cnt = 0;
    miso = ~miso;
  end
endmodule

//--- tb/tb.sv
module tb import spicsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, pd;
  logic              pready, pslverr, sck_out, sck_oe_n, mosi_out, mosi_oe_n;
  logic              miso_out, miso_oe_n, ss_owned, pullup_en, err, pmiso;
  logic              rx_irq_req, tx_irq_req, err_irq_req;
  logic              ss_drv = 1, psel_n = 1, pcpol = 0;
  logic [7:0]        ptx = '0, prx, q;
  int                mismatches = 0, checks = 0;
  // SCK and MOSI are pulled high when nobody drives them; undriven MISO shows the peer's output
  wire sck_w  = sck_oe_n ? 1'b1 : sck_out;
  wire mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
  wire miso_w = miso_oe_n ? pmiso : miso_out;

  always #50 pclk = ~pclk;

  spicsr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sck_in(sck_w), .sck_out, .sck_oe_n, .mosi_in(mosi_w), .mosi_out,
    .mosi_oe_n, .miso_in(miso_w), .miso_out, .miso_oe_n, .ss_n_in(ss_drv), .ss_owned,
    .pullup_en, .rx_irq_req, .tx_irq_req, .err_irq_req);
  spicsr_peer peer (.sck(sck_w), .mosi(mosi_w), .sel_n(psel_n), .cpol(pcpol), .tx(ptx),
    .miso(pmiso), .rx(prx));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo();
    end while (pready !== 1'b1);
    pd = prdata;
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      rd(ADDR_STAT);
      n++;
      if (n > 700) tmo();
    end while (q[b] !== 1'b1);
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] s, input logic [7:0] d,
                    input logic [7:0] p);
    apb(1'b1, ADDR_CTRL, c);
    apb(1'b1, ADDR_STAT, s);
    ptx <= p;
    psel_n <= 1'b0;
    apb(1'b1, ADDR_DATA, d);
    wait_st(B_RXF);
    psel_n <= 1'b1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(ADDR_CTRL);
    chk(q, CTRL_RST, "ctrl reset");
    rd(ADDR_STAT);
    chk(q, STAT_RST, "stat reset");
    rd(12'h000);
    chk(err, 1'b1, "unmapped err");
    chk(pd, 32'h0, "unmapped data");
    chk({pullup_en, ss_owned, rx_irq_req, tx_irq_req, err_irq_req}, 5'b10000, "pins");
    apb(1'b1, ADDR_CTRL, 8'h0A);
    cyc(2);
    chk(ss_owned, 1'b1, "slave owns select");
    chk({miso_oe_n, mosi_oe_n, sck_oe_n}, 3'b111, "deselected slave");
    $display("test reset done");
  endtask
  task automatic t_xfer;
    go(8'hAA, 8'h01, 8'hA5, 8'h3C);
    chk(prx, 8'hA5, "peer rx");
    chk(q[B_TXE], 1'b1, "tx empty");
    chk(sck_w, 1'b0, "sck idle");
    chk(rx_irq_req, 1'b1, "rx irq");
    rd(ADDR_DATA);
    chk(q, 8'h3C, "rx data");
    rd(ADDR_STAT);
    chk(q[B_RXF], 1'b0, "rx full clear");
    cyc(3);
    chk(rx_irq_req, 1'b0, "rx irq off");
    $display("test xfer done");
  endtask
  task automatic t_over;
    go(8'h2A, 8'h41, 8'h11, 8'h3C);
    cyc(1);
    ptx <= 8'h77;
    psel_n <= 1'b0;
    apb(1'b1, ADDR_DATA, 8'h22);
    wait_st(B_OVR);
    psel_n <= 1'b1;
    cyc(3);
    chk(err_irq_req, 1'b1, "err irq");
    rd(ADDR_DATA);
    chk(q, 8'h3C, "old byte kept");
    rd(ADDR_STAT);
    chk(q[7:5], 3'b010, "flags clear");
    cyc(3);
    chk(err_irq_req, 1'b0, "err irq off");
    $display("test overrun done");
  endtask
  task automatic t_rate;
    int   divs[4];
    int   n;
    logic s0;
    divs = '{DIV_0, DIV_1, DIV_2, DIV_3};
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ADDR_CTRL, 8'h2A);
      apb(1'b1, ADDR_STAT, 8'(r));
      psel_n <= 1'b0;
      apb(1'b1, ADDR_DATA, 8'(8'h50 + r));
      s0 = sck_out;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
        if (n > 300) tmo();
      end while (sck_out === s0);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
        if (n > 300) tmo();
      end while (sck_out !== s0);
      chk(n, divs[r] / 2, "half period");
      wait_st(B_RXF);
      chk(prx, 8'(8'h50 + r), "rate byte");
      rd(ADDR_DATA);
      psel_n <= 1'b1;
    end
    $display("test rate done");
  endtask
  task automatic t_od;
    pcpol <= 1'b1;
    go(8'h3E, 8'h01, 8'hC3, 8'h81);
    chk(prx, 8'hC3, "od peer rx");
    chk({pullup_en, sck_oe_n, sck_w}, 3'b011, "od idle");
    rd(ADDR_DATA);
    chk(q, 8'h81, "od rx");
    pcpol <= 1'b0;
    $display("test open drain done");
  endtask
  task automatic t_mode_fault_flag;
    apb(1'b1, ADDR_CTRL, 8'h2A);
    apb(1'b1, ADDR_STAT, 8'h00);
    ss_drv <= 1'b0;
    cyc(8);
    rd(ADDR_STAT);
    chk(q[B_MODE_FAULT_FLAG], 1'b0, "select ignored");
    chk(ss_owned, 1'b0, "select left free");
    ss_drv <= 1'b1;
    cyc(4);
    apb(1'b1, ADDR_STAT, 8'h04);
    cyc(2);
    chk(ss_owned, 1'b1, "master owns select");
    ss_drv <= 1'b0;
    wait_st(B_MODE_FAULT_FLAG);
    ss_drv <= 1'b1;
    rd(ADDR_CTRL);
    chk(q[B_MEN], 1'b0, "self disable");
    apb(1'b1, ADDR_STAT, 8'h40);
    rd(ADDR_STAT);
    chk(q[B_MODE_FAULT_FLAG], 1'b1, "fault kept");
    cyc(2);
    chk(err_irq_req, 1'b1, "fault irq");
    apb(1'b1, ADDR_CTRL, 8'h28);
    rd(ADDR_STAT);
    chk(q[B_MODE_FAULT_FLAG], 1'b0, "fault clear");
    $display("test fault done");
  endtask
  task automatic t_dis;
    apb(1'b1, ADDR_CTRL, 8'h2B);
    apb(1'b1, ADDR_STAT, 8'h03);
    ptx <= 8'h00;
    psel_n <= 1'b0;
    apb(1'b1, ADDR_DATA, 8'h99);
    cyc(2);
    rd(ADDR_STAT);
    chk(q[B_TXE], 1'b1, "handed over");
    apb(1'b1, ADDR_DATA, 8'h66);
    rd(ADDR_STAT);
    chk(q[B_TXE], 1'b0, "tx full");
    cyc(3);
    chk(tx_irq_req, 1'b0, "tx irq off");
    apb(1'b1, ADDR_CTRL, 8'h29);
    rd(ADDR_STAT);
    chk(q[B_TXE], 1'b1, "disable empties");
    cyc(3);
    chk(tx_irq_req, 1'b1, "tx irq");
    chk({sck_oe_n, mosi_oe_n}, 2'b11, "pins released");
    rd(ADDR_CTRL);
    chk(q, 8'h29, "ctrl kept");
    psel_n <= 1'b1;
    $display("test disable done");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_xfer();
    t_over();
    t_rate();
    t_od();
    t_mode_fault_flag();
    t_dis();
    summarize();
  end
endmodule
